// [design/eth_ctrl_pkg.sv]
// package: constants, field positions and carriers of the ethernet control bank
// assumes a single core clock and an apb master on the register side
// How it works
// - writing ones at base plus four clears those implemented bits
// - writing ones at base plus eight sets those implemented bits
// - writing ones at base plus twelve toggles those implemented bits
// - unimplemented control bits, 14, 12 to 10, 6 to 5 and 3 to 1, read zero, ignore writes
// - control bit 15 switches txGo, rxStoreEn and flow control on or off
// - bit 13 freezes transfers while the system idles
// - writing one to bit 9 starts transmission of the descriptor table
// - hardware clears bit 9 when all requested packets are sent
// - writing zero to bit 9 finishes current packet, starts no more
// - bit 8 gates storing of filtered received packets
// - implemented control bits reset to zero, unimplemented read zero
// - automatic mode flow on at full watermark, off at empty watermark
// - manual mode sends pause, resends every 64 times timer transmit ticks
// - leaving manual mode sends one pause frame with zero timer
// - decrement bit lowers buffer count, reads zero, cancels with increment
package eth_ctrl_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 8;
	localparam int PTV_W  = 16;

	// register bases, each with three alias words above it
	localparam logic [ADDR_W-1:0] OFS_SA_LOW  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SA_MID  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_SA_HIGH = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h30;
	localparam logic [1:0]        ALIAS_NONE  = 2'h0;
	localparam logic [1:0]        ALIAS_CLR   = 2'h1;
	localparam logic [1:0]        ALIAS_SET   = 2'h2;
	localparam logic [1:0]        ALIAS_INV   = 2'h3;
	localparam logic [1:0]        IDX_CTRL    = 2'h3;

	// control field positions
	localparam int PTV_LSB     = 16;
	localparam int BIT_ON      = 15;
	localparam int BIT_IDLE    = 13;
	localparam int BIT_TXREQ   = 9;
	localparam int BIT_RECEIVE_ENABLE    = 8;
	localparam int BIT_AUTOMATIC_FLOW_CONTROL  = 7;
	localparam int BIT_MANUAL_FLOW_CONTROL   = 4;
	localparam int BIT_BUFFER_COUNT_DECREMENT = 0;

	localparam logic [DATA_W-1:0] CTRL_STORE_MASK = 32'hFFFFA390;
	localparam logic [DATA_W-1:0] SA_MASK         = 32'h0000FFFF;
	localparam logic [DATA_W-1:0] CTRL_RESET      = 32'h00000000;
	localparam logic [15:0]       SA_RESET        = 16'h0000;
	localparam logic [CNT_W-1:0]  CNT_RESET       = 8'h00;
	localparam logic [CNT_W-1:0]  CNT_MAX         = 8'hFF;

	// pause resend interval: 128 * timer / 2 transmit clocks
	localparam int PAUSE_MULT   = 128 / 2;
	localparam int PAUSE_CNT_W  = 23;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic              pready;
		logic              pslverr;
		logic [DATA_W-1:0] prdata;
	} apb_rsp_t;

	typedef struct packed {
		logic             moduleOn;
		logic             frozen;
		logic             txGo;
		logic             rxStoreEn;
		logic             autoFlowOn;
		logic             flowActive;
		logic [PTV_W-1:0] pauseTimer;
		logic [47:0]      stationAddr;
	} ctrl_out_t;

endpackage : eth_ctrl_pkg

// [design/pause_sender.sv]
// pause frame scheduler for flow control
// assumes txClkTick pulses once per transmit clock, pauseAck once per frame sent
`timescale 1ns/1ns
`default_nettype none
module pause_sender (
	input  wire logic                           core_clk,
	input  wire logic                           rst,
	input  wire logic                           flowOn,
	input  wire logic [eth_ctrl_pkg::PTV_W-1:0] pauseTimer,
	input  wire logic                           txClkTick,
	input  wire logic                           pauseAck,
	output logic                                pauseReq,
	output logic      [eth_ctrl_pkg::PTV_W-1:0] pauseValue
);
	import eth_ctrl_pkg::*;

	typedef enum logic [1:0] {S_IDLE, S_SEND, S_WAIT, S_ZERO} pause_state_t;

	pause_state_t             state;
	logic [PAUSE_CNT_W-1:0]   tickCount;
	logic [PAUSE_CNT_W-1:0]   interval;
	logic                     enterZero;

	assign interval = PAUSE_CNT_W'(pauseTimer) * PAUSE_CNT_W'(PAUSE_MULT);
	// zero value must already stand in the first cycle of the ending request
	assign enterZero = !flowOn && ((state == S_WAIT) || (state == S_SEND && pauseAck));

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= S_IDLE;
		end else begin
			case (state)
				S_IDLE: if (flowOn) state <= S_SEND;
				S_SEND: if (pauseAck) state <= flowOn ? S_WAIT : S_ZERO;
				S_WAIT: begin
					if (!flowOn) state <= S_ZERO;
					else if (tickCount >= interval) state <= S_SEND;
				end
				S_ZERO: if (pauseAck) state <= S_IDLE;
				default: state <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) tickCount <= '0;
		else if (state != S_WAIT) tickCount <= '0;
		else if (txClkTick) tickCount <= tickCount + PAUSE_CNT_W'(1);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) pauseValue <= '0;
		else if (state == S_ZERO || enterZero) pauseValue <= '0;
		else pauseValue <= pauseTimer;
	end

	assign pauseReq = (state == S_SEND) || (state == S_ZERO);

endmodule : pause_sender
`default_nettype wire

// [design/eth_ctrl_bank.sv]
// ethernet control register bank: station address, main control, buffer count
// assumes an apb master, and mac, dma and filter logic on the user side
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module eth_ctrl_bank (
	input  wire logic                           core_clk,
	input  wire logic                           rst,
	input  wire eth_ctrl_pkg::apb_req_t         apbReq,
	output eth_ctrl_pkg::apb_rsp_t              apbRsp,
	input  wire logic                           sysIdle,
	input  wire logic                           txAllDone,
	input  wire logic                           rxFilterAccept,
	input  wire logic                           rxBufInc,
	input  wire logic [eth_ctrl_pkg::CNT_W-1:0] fullWatermark,
	input  wire logic [eth_ctrl_pkg::CNT_W-1:0] emptyWatermark,
	input  wire logic                           txClkTick,
	input  wire logic                           pauseAck,
	output eth_ctrl_pkg::ctrl_out_t             ctrlOut,
	output logic      [eth_ctrl_pkg::CNT_W-1:0] bufferCount,
	output logic                                pauseReq,
	output logic      [eth_ctrl_pkg::PTV_W-1:0] pauseValue
);
	import eth_ctrl_pkg::*;

	// address decode helpers
	function automatic logic addrHit(input logic [ADDR_W-1:0] addr);
		addrHit = (addr[ADDR_W-1:6] == '0) && (addr[1:0] == 2'h0);
	endfunction : addrHit

	function automatic logic [1:0] aliasKind(input logic [ADDR_W-1:0] addr);
		aliasKind = addr[3:2];
	endfunction : aliasKind

	function automatic logic [1:0] regIndex(input logic [ADDR_W-1:0] addr);
		regIndex = addr[5:4];
	endfunction : regIndex

	// effect of a write at base or alias on the stored bits
	function automatic logic [DATA_W-1:0] applyWrite(
		input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] data,
		input logic [1:0]        kind,
		input logic [DATA_W-1:0] mask
	);
		logic [DATA_W-1:0] m;
		m = data & mask;
		case (kind)
			ALIAS_NONE: applyWrite = (old & ~mask) | m;
			ALIAS_CLR:  applyWrite = old & ~m;
			ALIAS_SET:  applyWrite = old | m;
			ALIAS_INV:  applyWrite = old ^ m;
			default:    applyWrite = old;
		endcase
	endfunction : applyWrite

	logic                     setupPhase;
	logic                     accessPhase;
	logic                     wrStrobe;
	logic                     hit;
	logic [1:0]               kind;
	logic [1:0]               index;
	logic                     ctrlWrite;
	logic [DATA_W-1:0]        ctrlReg;
	logic [DATA_W-1:0]        ctrlBase;
	logic [DATA_W-1:0]        next_ctrl;
	logic [15:0]              stationReg [3];
	logic                     decStrobe;
	logic                     autoFlowState;
	logic [DATA_W-1:0]        readValue;
	logic [DATA_W-1:0]        prdataReg;
	logic                     pslverrReg;
	logic                     moduleOn;
	logic                     frozen;
	logic                     flowOn;

	// apb phases: zero wait states
	assign setupPhase  = apbReq.psel && !apbReq.penable;
	assign accessPhase = apbReq.psel && apbReq.penable;
	assign hit         = addrHit(apbReq.paddr);
	assign kind        = aliasKind(apbReq.paddr);
	assign index       = regIndex(apbReq.paddr);
	assign wrStrobe    = accessPhase && apbReq.pwrite && hit;
	assign ctrlWrite   = wrStrobe && (index == IDX_CTRL);

	// station address, two bytes per register
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_station
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					stationReg[g] <= SA_RESET;
				end else if (wrStrobe && (index == 2'(g))) begin
					stationReg[g] <= 16'(applyWrite(
						{16'h0000, stationReg[g]}, apbReq.pwdata, kind, SA_MASK
					));
				end
			end
		end
	endgenerate

	// hardware clear of the transmit request happens before the write lands,
	// so a write of one in the same cycle still wins
	always_comb begin
		ctrlBase = ctrlReg;
		if (txAllDone) begin
			ctrlBase[BIT_TXREQ] = 1'b0;
		end
	end

	always_comb begin
		next_ctrl = ctrlBase;
		if (ctrlWrite) begin
			next_ctrl = applyWrite(ctrlBase, apbReq.pwdata, kind,
				CTRL_STORE_MASK);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrlReg <= CTRL_RESET;
		end else begin
			ctrlReg <= next_ctrl & CTRL_STORE_MASK;
		end
	end

	// decrement strobe: any write that would put a one in bit 0
	always_comb begin
		decStrobe = 1'b0;
		if (ctrlWrite && apbReq.pwdata[BIT_BUFFER_COUNT_DECREMENT]) begin
			case (kind)
				ALIAS_NONE: decStrobe = 1'b1;
				ALIAS_SET:  decStrobe = 1'b1;
				ALIAS_INV:  decStrobe = 1'b1;
				ALIAS_CLR:  decStrobe = 1'b0;
				default:    decStrobe = 1'b0;
			endcase
		end
	end

	// descriptor buffer count
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bufferCount <= CNT_RESET;
		end else if (rxBufInc && !decStrobe) begin
			if (bufferCount != CNT_MAX) bufferCount <= bufferCount + CNT_W'(1);
		end else if (decStrobe && !rxBufInc) begin
			if (bufferCount != CNT_RESET) bufferCount <= bufferCount - CNT_W'(1);
		end
	end

	// automatic flow control with watermark hysteresis
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			autoFlowState <= 1'b0;
		end else if (!ctrlReg[BIT_AUTOMATIC_FLOW_CONTROL] || !moduleOn) begin
			autoFlowState <= 1'b0;
		end else if (bufferCount >= fullWatermark) begin
			autoFlowState <= 1'b1;
		end else if (bufferCount <= emptyWatermark) begin
			autoFlowState <= 1'b0;
		end
	end

	assign moduleOn = ctrlReg[BIT_ON];
	assign frozen   = ctrlReg[BIT_IDLE] && sysIdle;
	assign flowOn   = moduleOn && (ctrlReg[BIT_MANUAL_FLOW_CONTROL] || autoFlowState);

	// pause frame scheduling
	pause_sender u_pause (
		.core_clk   (core_clk),
		.rst        (rst),
		.flowOn     (flowOn),
		.pauseTimer (ctrlReg[PTV_LSB +: PTV_W]),
		.txClkTick  (txClkTick && !frozen),
		.pauseAck   (pauseAck),
		.pauseReq   (pauseReq),
		.pauseValue (pauseValue)
	);

	// outputs toward mac, dma and filter
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrlOut <= '0;
		end else begin
			ctrlOut.moduleOn    <= moduleOn;
			ctrlOut.frozen      <= frozen;
			ctrlOut.txGo        <= moduleOn && !frozen
				&& next_ctrl[BIT_TXREQ];
			ctrlOut.rxStoreEn   <= moduleOn && !frozen && ctrlReg[BIT_RECEIVE_ENABLE]
				&& rxFilterAccept;
			ctrlOut.autoFlowOn  <= autoFlowState;
			ctrlOut.flowActive  <= flowOn;
			ctrlOut.pauseTimer  <= ctrlReg[PTV_LSB +: PTV_W];
			ctrlOut.stationAddr <= {stationReg[0], stationReg[1],
				stationReg[2]};
		end
	end

	// read mux: aliases return zero
	always_comb begin
		readValue = '0;
		if (hit && (kind == ALIAS_NONE)) begin
			case (index)
				2'h0:    readValue = {16'h0000, stationReg[0]};
				2'h1:    readValue = {16'h0000, stationReg[1]};
				2'h2:    readValue = {16'h0000, stationReg[2]};
				IDX_CTRL: readValue = ctrlReg & CTRL_STORE_MASK;
				default: readValue = '0;
			endcase
		end
	end

	// read data and error captured in the setup cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prdataReg  <= '0;
			pslverrReg <= 1'b0;
		end else if (setupPhase) begin
			prdataReg  <= apbReq.pwrite ? '0 : readValue;
			pslverrReg <= !hit;
		end
	end

	assign apbRsp.pready  = accessPhase;
	assign apbRsp.pslverr = accessPhase && pslverrReg;
	assign apbRsp.prdata  = prdataReg;

endmodule : eth_ctrl_bank
`default_nettype wire

// [bench/eth_ctrl_bank_asserts.sv]
// checker: port-level timing of the ethernet control bank
// assumes the bank ports only, bound below
`timescale 1ns/1ns
`default_nettype none
module eth_ctrl_bank_asserts
	import eth_ctrl_pkg::*;
(
	input wire logic                           core_clk,
	input wire logic                           rst,
	input wire eth_ctrl_pkg::apb_req_t         apbReq,
	input wire eth_ctrl_pkg::apb_rsp_t         apbRsp,
	input wire logic                           sysIdle,
	input wire logic                           txAllDone,
	input wire logic                           rxFilterAccept,
	input wire logic                           rxBufInc,
	input wire logic [eth_ctrl_pkg::CNT_W-1:0] fullWatermark,
	input wire logic [eth_ctrl_pkg::CNT_W-1:0] emptyWatermark,
	input wire logic                           txClkTick,
	input wire logic                           pauseAck,
	input wire eth_ctrl_pkg::ctrl_out_t        ctrlOut,
	input wire logic [eth_ctrl_pkg::CNT_W-1:0] bufferCount,
	input wire logic                           pauseReq,
	input wire logic [eth_ctrl_pkg::PTV_W-1:0] pauseValue
);
	logic wrAcc;
	logic rdAcc;
	logic decWr;
	assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
	assign rdAcc = apbReq.psel && apbReq.penable && !apbReq.pwrite;
	assign decWr = wrAcc && apbReq.paddr == OFS_CTRL && apbReq.pwdata[BIT_BUFFER_COUNT_DECREMENT];
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_on_follows: assert property (wrAcc && apbReq.paddr == OFS_CTRL |-> ##2
		ctrlOut.moduleOn == $past(apbReq.pwdata[BIT_ON], 2)) else $error("module on mismatch");
	a_unimpl_zero: assert property (rdAcc && apbReq.paddr == OFS_CTRL |->
		(apbRsp.prdata & ~CTRL_STORE_MASK) == 32'h00000000) else $error("unused bits set");
	a_sa_upper: assert property (rdAcc && apbReq.paddr[5:4] != 2'h3 |->
		apbRsp.prdata[31:16] == 16'h0000) else $error("address upper half set");
	a_frozen_idle: assert property (ctrlOut.frozen |-> $past(sysIdle))
		else $error("frozen without idle");
	a_rx_gate: assert property (ctrlOut.rxStoreEn |-> ctrlOut.moduleOn && !ctrlOut.frozen
		&& $past(rxFilterAccept)) else $error("receive store ungated");
	a_tx_done: assert property (txAllDone && !wrAcc |=> !ctrlOut.txGo)
		else $error("transmit stays after done");
	a_cnt_cancel: assert property (decWr && rxBufInc |=> $stable(bufferCount))
		else $error("count moved on cancel");
	a_cnt_dec: assert property (decWr && !rxBufInc && bufferCount != 8'h00 |=>
		bufferCount == $past(bufferCount) - 8'h01) else $error("count not decremented");
	a_pause_hold: assert property (pauseReq && !pauseAck |=> pauseReq)
		else $error("pause request dropped");
endmodule : eth_ctrl_bank_asserts
bind eth_ctrl_bank eth_ctrl_bank_asserts eth_ctrl_bank_asserts_inst (.core_clk(core_clk),
	.rst(rst), .apbReq(apbReq), .apbRsp(apbRsp), .sysIdle(sysIdle), .txAllDone(txAllDone),
	.rxFilterAccept(rxFilterAccept), .rxBufInc(rxBufInc), .fullWatermark(fullWatermark),
	.emptyWatermark(emptyWatermark), .txClkTick(txClkTick), .pauseAck(pauseAck),
	.ctrlOut(ctrlOut), .bufferCount(bufferCount), .pauseReq(pauseReq), .pauseValue(pauseValue));
`default_nettype wire

// [bench/testbench.sv]
// testbench: register traffic, buffer count, gates and pause frames
// assumes a zero-wait apb slave and registered control outputs
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import eth_ctrl_pkg::*;
	logic             core_clk, rst, sysIdle, txAllDone, rxBufInc, pauseAck, err, rxAcc;
	apb_req_t         req;
	apb_rsp_t         rsp;
	ctrl_out_t        co;
	logic [CNT_W-1:0] cnt;
	logic             pReq;
	logic [PTV_W-1:0] pVal;
	logic [31:0]      rnd, q, wd, mdl [4];
	int               nMismatch, checked, n;
	eth_ctrl_bank eth_ctrl_bank_inst (.core_clk(core_clk), .rst(rst), .apbReq(req), .apbRsp(rsp),
		.sysIdle(sysIdle), .txAllDone(txAllDone), .rxFilterAccept(rxAcc), .rxBufInc(rxBufInc),
		.fullWatermark(8'h04), .emptyWatermark(8'h02), .txClkTick(1'b1), .pauseAck(pauseAck),
		.ctrlOut(co), .bufferCount(cnt), .pauseReq(pReq), .pauseValue(pVal));
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	task complete_run;
		$display("checks %0d mismatches %0d", checked, nMismatch);
		if (nMismatch == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
		checked++;
		if (seen !== exp) begin
			nMismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		n = 0;
		@(posedge core_clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge core_clk);
		req.penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		q = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		if (rsp.pready !== 1'b1) begin
			nMismatch++;
			complete_run();
		end
	endtask : apb
	task at(input int k);
		repeat (k) @(posedge core_clk);
		@(negedge core_clk);
	endtask : at
	task ack;
		@(posedge core_clk);
		pauseAck <= 1'b1;
		@(posedge core_clk);
		pauseAck <= 1'b0;
	endtask : ack
	task waitReq;
		n = 0;
		while (pReq !== 1'b1 && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		if (pReq !== 1'b1) begin
			nMismatch++;
			complete_run();
		end
	endtask : waitReq
	function automatic logic [31:0] upd(logic [31:0] o, d, m, logic [1:0] k);
		case (k)
			ALIAS_CLR: return o & ~(d & m);
			ALIAS_SET: return o | (d & m);
			ALIAS_INV: return o ^ (d & m);
			default: return (o & ~m) | (d & m);
		endcase
	endfunction : upd
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	initial begin
		{rst, sysIdle, txAllDone, rxBufInc, pauseAck, err} = 6'h20;
		req = '0;
		rxAcc = 1'b1;
		rnd = 32'h00013D76;
		nMismatch = 0;
		checked = 0;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		for (int r = 0; r < 4; r++) begin
			apb(1'b0, 8'(r * 16), 32'h00000000);
			chk("reset value", q, 48'h0);
			mdl[r] = 32'h00000000;
		end
		apb(1'b0, 8'h40, 32'h00000000);
		chk("unmapped error", err, 48'h1);
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			wd = (i % 4 == 3 && mdl[3][BIT_RECEIVE_ENABLE]) ? {16'h0000, rnd[15:0]} : rnd;
			apb(1'b1, 8'((i % 4) * 16 + (i / 4) * 4), wd);
			mdl[i % 4] = upd(mdl[i % 4], wd, (i % 4 == 3) ? CTRL_STORE_MASK : SA_MASK, 2'(i / 4));
			apb(1'b0, 8'((i % 4) * 16), 32'h00000000);
			chk("register value", q, mdl[i % 4]);
		end
		at(1);
		chk("station address", co.stationAddr, {mdl[0][15:0], mdl[1][15:0], mdl[2][15:0]});
		apb(1'b1, OFS_CTRL + 8'h04, 32'h00000100);
		apb(1'b1, OFS_CTRL, 32'h00000000);
		rxBufInc <= 1'b1;
		repeat (3) @(posedge core_clk);
		rxBufInc <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h00000001);
		rxBufInc <= 1'b1;
		apb(1'b1, OFS_CTRL, 32'h00008081);
		rxBufInc <= 1'b0;
		at(3);
		chk("buffer count", cnt, 48'h4);
		chk("auto flow on", {co.autoFlowOn, co.flowActive}, 48'h3);
		apb(1'b1, OFS_CTRL + 8'h08, 32'h00000001);
		apb(1'b1, OFS_CTRL + 8'h0C, 32'h00000001);
		at(3);
		chk("buffer count", cnt, 48'h2);
		chk("auto flow off", {co.autoFlowOn, co.flowActive}, 48'h0);
		apb(1'b1, OFS_CTRL, 32'h00008200);
		at(2);
		chk("transmit go", co.txGo, 48'h1);
		@(posedge core_clk);
		txAllDone <= 1'b1;
		@(posedge core_clk);
		txAllDone <= 1'b0;
		at(2);
		chk("transmit done", co.txGo, 48'h0);
		apb(1'b1, OFS_CTRL + 8'h08, 32'h00000200);
		at(2);
		chk("transmit again", co.txGo, 48'h1);
		apb(1'b1, OFS_CTRL + 8'h04, 32'h00000200);
		at(2);
		chk("transmit stop", co.txGo, 48'h0);
		apb(1'b1, OFS_CTRL + 8'h08, 32'h00002300);
		sysIdle <= 1'b1;
		at(2);
		chk("idle gates", {co.frozen, co.txGo, co.rxStoreEn}, 48'h4);
		@(posedge core_clk);
		sysIdle <= 1'b0;
		at(2);
		chk("awake gates", {co.frozen, co.txGo, co.rxStoreEn}, 48'h3);
		@(posedge core_clk);
		rxAcc <= 1'b0;
		at(2);
		chk("filter reject", co.rxStoreEn, 48'h0);
		apb(1'b1, OFS_CTRL + 8'h04, 32'h00008100);
		at(2);
		chk("module off", {co.moduleOn, co.txGo, co.rxStoreEn}, 48'h0);
		repeat (3) begin
			ack();
			at(2);
		end
		apb(1'b1, OFS_CTRL, 32'h00018010);
		at(0);
		waitReq();
		chk("pause value", pVal, 48'h1);
		chk("pause timer", co.pauseTimer, 48'h1);
		ack();
		at(0);
		waitReq();
		chk("resend interval", 48'(n >= 60 && n <= 70), 48'h1);
		ack();
		apb(1'b1, OFS_CTRL + 8'h04, 32'h00000010);
		at(0);
		waitReq();
		chk("ending pause", pVal, 48'h0);
		ack();
		at(4);
		chk("pause over", pReq, 48'h0);
		complete_run();
	end
endmodule : testbench
`default_nettype wire
